// [verilog/solar_switch_block.sv]
`timescale 1ns/10ps
`include "solar_switch_map.svh"

// Function
// - Output high between sunrise and sunset only.
// - Event times derived internally, no external trigger.
// - Longitude: direction, degrees 0-180, minutes, seconds.
// - Latitude: direction, degrees 0-90, minutes, seconds.
// - Whole-hour zone -11..12 used in calculation.
// - Sunrise offset -59..59 minutes applied.
// - Sunset offset -59..59 minutes applied.
// - Enabled summertime shifts both event times.
module solar_switch_block (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  input  wire logic [10:0] current_time_of_day_in,
  input  wire logic [8:0]  day_of_year_in,
  output logic [31:0]      rd_data_out,
  output logic             switch_out,
  output logic [10:0]      sunrise_time_out,
  output logic [10:0]      sunset_time_out
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------

  // Packs a coordinate into its register word layout.
  function automatic logic [31:0] pack_geo(input solar_switch_pkg::geo_pos_t g);
    logic [31:0] w;
    w = '0;
    w[`GEO_DIR_BIT]        = g.dir;
    w[`GEO_DEG_LSB +: 8]   = g.deg;
    w[`GEO_MIN_LSB +: 6]   = g.arcmin;
    w[`GEO_SEC_LSB +: 6]   = g.arcsec;
    return w;
  endfunction

  // Unpacks a written coordinate and pulls each field into range.
  // Fields are clamped one by one, so 180 deg 30 min is kept as written.
  function automatic solar_switch_pkg::geo_pos_t clamp_geo(input logic [31:0] w,
                                                           input logic [7:0]  deg_max);
    solar_switch_pkg::geo_pos_t g;
    g.dir    = w[`GEO_DIR_BIT];
    g.deg    = (w[`GEO_DEG_LSB +: 8] > deg_max) ? deg_max : w[`GEO_DEG_LSB +: 8];
    g.arcmin = (w[`GEO_MIN_LSB +: 6] > `ARC_MAX) ? `ARC_MAX : w[`GEO_MIN_LSB +: 6];
    g.arcsec = (w[`GEO_SEC_LSB +: 6] > `ARC_MAX) ? `ARC_MAX : w[`GEO_SEC_LSB +: 6];
    return g;
  endfunction

  // Clamps a signed byte into lo..hi.
  function automatic logic signed [7:0] clamp_s8(input logic signed [7:0] v,
                                                 input logic signed [7:0] lo,
                                                 input logic signed [7:0] hi);
    logic signed [7:0] r;
    r = v;
    if (v < lo) r = lo;
    if (v > hi) r = hi;
    return r;
  endfunction

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------

  solar_switch_pkg::solar_cfg_t   cfg_d;     // Next configuration.
  solar_switch_pkg::solar_cfg_t   cfg_q;     // Live, always legal configuration.
  logic                           clamp_d;   // Next sticky clamp flag.
  logic                           clamp_q;   // Set when a write was pulled into range.
  solar_switch_pkg::geo_pos_t     geo_w;     // Clamped coordinate from the write word.
  logic signed [7:0]              byte_w;    // Signed low byte of the write word.
  logic signed [7:0]              byte_c;    // That byte after clamping.
  logic                           hit;       // This write needed clamping.

  // Writes are decoded here. Every value is clamped before it is stored,
  // so the calculator never sees an illegal setting. Writes to read-only
  // or unmapped addresses are dropped without effect.
  always_comb begin
    cfg_d   = cfg_q;
    hit     = 1'b0;
    byte_w  = signed'(wr_data_in[7:0]);
    byte_c  = byte_w;
    geo_w   = '0;
    clamp_d = clamp_q;
    if (wr_en_in) begin
      unique case (addr_in)
        `ADDR_LONGITUDE: begin
          geo_w     = clamp_geo(wr_data_in, `LON_DEG_MAX);
          cfg_d.lon = geo_w;
          hit       = pack_geo(geo_w) != (wr_data_in & pack_geo('1));
        end
        `ADDR_LATITUDE: begin
          geo_w     = clamp_geo(wr_data_in, `LAT_DEG_MAX);
          cfg_d.lat = geo_w;
          hit       = pack_geo(geo_w) != (wr_data_in & pack_geo('1));
        end
        `ADDR_ZONE: begin
          byte_c     = clamp_s8(byte_w, `ZONE_MIN, `ZONE_MAX);
          cfg_d.zone = byte_c[4:0];
          hit        = byte_c != byte_w;
        end
        `ADDR_RISE_OFS: begin
          byte_c         = clamp_s8(byte_w, `OFS_MIN, `OFS_MAX);
          cfg_d.rise_ofs = byte_c[6:0];
          hit            = byte_c != byte_w;
        end
        `ADDR_SET_OFS: begin
          byte_c        = clamp_s8(byte_w, `OFS_MIN, `OFS_MAX);
          cfg_d.set_ofs = byte_c[6:0];
          hit           = byte_c != byte_w;
        end
        `ADDR_SUMMERTIME: begin
          cfg_d.dst_en    = wr_data_in[`DST_EN_BIT];
          cfg_d.dst_hours = wr_data_in[`DST_HOURS_LSB +: 2];
        end
        `ADDR_STATUS: begin
          // Writing one clears the clamp flag.
          if (wr_data_in[`STAT_CLAMP_BIT]) begin
            clamp_d = 1'b0;
          end
        end
        default: begin
          // Unmapped or read-only: ignored.
        end
      endcase
    end
    // A clamp in the same cycle as the clear wins, so no event is lost.
    if (hit) begin
      clamp_d = 1'b1;
    end
  end

  // Configuration register bank. Reset gives equator, prime meridian,
  // zone zero, no offsets and summertime off with one hour prepared.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_q.lon       <= '0;
      cfg_q.lat       <= '0;
      cfg_q.zone      <= `RST_ZONE;
      cfg_q.rise_ofs  <= `RST_OFS;
      cfg_q.set_ofs   <= `RST_OFS;
      cfg_q.dst_en    <= 1'b0;
      cfg_q.dst_hours <= `RST_DST_HOURS;
      clamp_q         <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      clamp_q <= clamp_d;
    end
  end

  // --------------------------------------------------------------------
  // Event calculation and window comparison
  // --------------------------------------------------------------------

  solar_switch_pkg::event_times_t times;   // Registered sunrise and sunset.
  logic                           sw;      // Registered switch level.

  // Recomputed from the live configuration and date on every clock, so a
  // new setting takes effect two clocks later and a new day one clock later, by itself.
  solar_event_calc u_calc (
    .clk_in         (clk_in),
    .sys_rst_in     (sys_rst_in),
    .cfg_in         (cfg_q),
    .day_of_year_in (day_of_year_in),
    .times_out      (times)
  );

  // The time of day comes from the clock logic on this same clock, so it
  // is used without synchronising flip-flops.
  window_compare u_cmp (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .times_in   (times),
    .now_in     (current_time_of_day_in),
    .switch_out (sw)
  );

  assign switch_out       = sw;
  assign sunrise_time_out = times.sunrise_time;
  assign sunset_time_out  = times.sunset_time;

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------

  logic [31:0] rd_data_d;  // Read word selected in the strobe cycle.
  logic [31:0] rd_data_q;  // Read word presented one cycle later.

  // Reads return the stored, clamped values, so software can see what a
  // write was turned into. Unmapped addresses read as zero.
  always_comb begin
    rd_data_d = '0;
    if (rd_en_in) begin
      unique case (addr_in)
        `ADDR_LONGITUDE:  rd_data_d = pack_geo(cfg_q.lon);
        `ADDR_LATITUDE:   rd_data_d = pack_geo(cfg_q.lat);
        `ADDR_ZONE:       rd_data_d = 32'(signed'(cfg_q.zone));
        `ADDR_RISE_OFS:   rd_data_d = 32'(signed'(cfg_q.rise_ofs));
        `ADDR_SET_OFS:    rd_data_d = 32'(signed'(cfg_q.set_ofs));
        `ADDR_SUMMERTIME: begin
          rd_data_d[`DST_EN_BIT]         = cfg_q.dst_en;
          rd_data_d[`DST_HOURS_LSB +: 2] = cfg_q.dst_hours;
        end
        `ADDR_STATUS: begin
          rd_data_d[`STAT_SWITCH_BIT] = sw;
          rd_data_d[`STAT_CLAMP_BIT]  = clamp_q;
        end
        `ADDR_EVENTS: begin
          rd_data_d[`EVT_RISE_LSB +: 11] = times.sunrise_time;
          rd_data_d[`EVT_SET_LSB +: 11]  = times.sunset_time;
        end
        default: rd_data_d = '0;
      endcase
    end
  end

  // Read data stand for exactly one cycle and are zero otherwise.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data_out = rd_data_q;

endmodule

// [verilog/solar_switch_map.svh]
`ifndef SOLAR_SWITCH_MAP_SVH
`define SOLAR_SWITCH_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port).
// ----------------------------------------------------------------------
`define ADDR_LONGITUDE   8'h00
`define ADDR_LATITUDE    8'h04
`define ADDR_ZONE        8'h08
`define ADDR_RISE_OFS    8'h0c
`define ADDR_SET_OFS     8'h10
`define ADDR_SUMMERTIME  8'h14
`define ADDR_STATUS      8'h18
`define ADDR_EVENTS      8'h1c

// ----------------------------------------------------------------------
// Field positions of the longitude and latitude words.
// ----------------------------------------------------------------------
`define GEO_SEC_LSB      0
`define GEO_MIN_LSB      8
`define GEO_DEG_LSB      16
`define GEO_DIR_BIT      24

// ----------------------------------------------------------------------
// Field positions of the summertime, status and event-time words.
// ----------------------------------------------------------------------
`define DST_EN_BIT       0
`define DST_HOURS_LSB    1
`define STAT_SWITCH_BIT  0
`define STAT_CLAMP_BIT   1
`define EVT_RISE_LSB     0
`define EVT_SET_LSB      16

// ----------------------------------------------------------------------
// Legal limits of the configuration fields.
// ----------------------------------------------------------------------
`define LON_DEG_MAX      8'hb4
`define LAT_DEG_MAX      8'h5a
`define ARC_MAX          6'h3b
`define ZONE_MIN         8'shf5
`define ZONE_MAX         8'sh0c
`define OFS_MIN          8'shc5
`define OFS_MAX          8'sh3b

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define RST_ZONE         5'h00
`define RST_OFS          7'h00
`define RST_DST_HOURS    2'h1

// ----------------------------------------------------------------------
// Day arithmetic constants, in minutes and days.
// ----------------------------------------------------------------------
`define MIN_PER_DAY      14'sh05a0
`define MIN_PER_HOUR     14'sh003c
`define NOON_MIN         14'sh02d0
`define HALF_DAY_BASE    14'sh0168
`define HALF_DAY_MAX     14'sh02d0
`define ARCMIN_PER_TMIN  15'h000f
`define SOLSTICE_DAY     10'sh0ac
`define QUARTER_YEAR     10'sh05b
`define SEASON_DIV       22'sh00780

`endif

// [verilog/solar_switch_pkg.sv]
package solar_switch_pkg;

  // One geographic coordinate: hemisphere flag, degrees, arc-minutes, arc-seconds.
  typedef struct packed {
    logic       dir;
    logic [7:0] deg;
    logic [5:0] arcmin;
    logic [5:0] arcsec;
  } geo_pos_t;

  // Whole configuration as held after clamping.
  typedef struct packed {
    geo_pos_t          lon;
    geo_pos_t          lat;
    logic signed [4:0] zone;
    logic signed [6:0] rise_ofs;
    logic signed [6:0] set_ofs;
    logic              dst_en;
    logic [1:0]        dst_hours;
  } solar_cfg_t;

  // Event times as minutes of the day.
  typedef struct packed {
    logic [10:0] sunrise_time;
    logic [10:0] sunset_time;
  } event_times_t;

endpackage

// [verilog/solar_event_calc.sv]
`timescale 1ns/10ps
`include "solar_switch_map.svh"

// Approximate sunrise and sunset calculator, one result per clock.
module solar_event_calc (
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire solar_switch_pkg::solar_cfg_t  cfg_in,
  input  wire logic [8:0]                    day_of_year_in,
  output solar_switch_pkg::event_times_t     times_out
);

  // Folds a signed minute count into 0..1439.
  function automatic logic [10:0] wrap_day(input logic signed [13:0] v);
    logic signed [13:0] t;
    t = v;
    if (t < 14'sh0000) t = t + `MIN_PER_DAY;
    if (t < 14'sh0000) t = t + `MIN_PER_DAY;
    if (t >= `MIN_PER_DAY) t = t - `MIN_PER_DAY;
    if (t >= `MIN_PER_DAY) t = t - `MIN_PER_DAY;
    return t[10:0];
  endfunction

  logic [14:0]               lon_arcmin;  // Longitude in arc-minutes.
  logic signed [13:0]        lon_tmin;    // Longitude as minutes of time, east positive.
  logic signed [13:0]        lat_arcmin;  // Latitude in arc-minutes, north positive.
  logic signed [9:0]         season;      // Seasonal swing, +91 at midsummer.
  logic signed [21:0]        swing;       // Half-day span change in minutes.
  logic signed [13:0]        half_day;    // Half of the daylight span.
  logic signed [13:0]        noon;        // Local noon in zone time.
  solar_switch_pkg::event_times_t times_d;
  solar_switch_pkg::event_times_t times_q;

  // Solar noon follows longitude, zone and summertime; the span follows
  // latitude and season. A coarse model: good enough for switching lights.
  always_comb begin
    lon_arcmin = 15'(cfg_in.lon.deg) * 15'h003c + 15'(cfg_in.lon.arcmin);
    lon_tmin   = 14'(lon_arcmin / `ARCMIN_PER_TMIN);
    if (cfg_in.lon.dir) lon_tmin = -lon_tmin;
    noon = `NOON_MIN + 14'(cfg_in.zone) * `MIN_PER_HOUR - lon_tmin;
    if (cfg_in.dst_en) begin
      noon = noon + 14'(signed'({1'b0, cfg_in.dst_hours})) * `MIN_PER_HOUR;
    end
    lat_arcmin = 14'(cfg_in.lat.deg) * 14'sh003c + 14'(cfg_in.lat.arcmin);
    if (cfg_in.lat.dir) lat_arcmin = -lat_arcmin;
    season = signed'({1'b0, day_of_year_in}) - `SOLSTICE_DAY;
    if (season < 10'sh000) season = -season;
    season = `QUARTER_YEAR - season;
    if (season < -`QUARTER_YEAR) season = -`QUARTER_YEAR;
    swing    = (22'(lat_arcmin) * 22'(season)) / `SEASON_DIV;
    half_day = `HALF_DAY_BASE + 14'(swing);
    if (half_day < 14'sh0000) half_day = 14'sh0000;
    if (half_day > `HALF_DAY_MAX) half_day = `HALF_DAY_MAX;
    times_d.sunrise_time = wrap_day(noon - half_day + 14'(cfg_in.rise_ofs));
    times_d.sunset_time  = wrap_day(noon + half_day + 14'(cfg_in.set_ofs));
  end

  // Results are registered so the comparison sees a stable pair.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      times_q <= '0;
    end else begin
      times_q <= times_d;
    end
  end

  assign times_out = times_q;

endmodule

// [verilog/window_compare.sv]
`timescale 1ns/10ps

// Compares the time of day against the daylight window.
module window_compare (
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire solar_switch_pkg::event_times_t times_in,
  input  wire logic [10:0]                   now_in,
  output logic                               switch_out
);

  logic switch_d;  // Next switch level.
  logic switch_q;  // Registered switch level.

  // A window whose sunset falls after midnight wraps round the day end.
  // Sunrise is inside the window, sunset is not; equal times mean no daylight.
  always_comb begin
    if (times_in.sunrise_time < times_in.sunset_time) begin
      switch_d = (now_in >= times_in.sunrise_time) &&
                 (now_in < times_in.sunset_time);
    end else if (times_in.sunrise_time > times_in.sunset_time) begin
      switch_d = (now_in >= times_in.sunrise_time) ||
                 (now_in < times_in.sunset_time);
    end else begin
      switch_d = 1'b0;
    end
  end

  // Evaluated on every clock, with no outside trigger.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      switch_q <= 1'b0;
    end else begin
      switch_q <= switch_d;
    end
  end

  assign switch_out = switch_q;

endmodule

// [verif/solar_switch_monitor.sv]
`timescale 1ns/10ps
`include "solar_switch_map.svh"

// ------------------------------------------------------------
// Port checker for the daylight switch.
// ------------------------------------------------------------
module solar_switch_monitor (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [10:0] current_time_of_day_in,
  input wire logic [8:0]  day_of_year_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        switch_out,
  input wire logic [10:0] sunrise_time_out,
  input wire logic [10:0] sunset_time_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Equal event times give no daylight, so a reset-time pair of zeros keeps the switch off.
  function automatic logic in_win(logic [10:0] r, logic [10:0] s, logic [10:0] t);
    if (r < s) return (t >= r) && (t < s);
    if (s < r) return (t >= r) || (t < s);
    return 1'b0;
  endfunction

  AST_SWITCH_WINDOW: assert property (
    switch_out == in_win($past(sunrise_time_out), $past(sunset_time_out),
                         $past(current_time_of_day_in))) else $error("switch off window");
  AST_STATUS_SWITCH: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_STATUS |-> rd_data_out[0] == $past(switch_out))
    else $error("status switch bit wrong");
  AST_TIMES_STEADY: assert property (
    !$past(sys_rst_in) && !$past(sys_rst_in, 2) && !$past(wr_en_in) && !$past(wr_en_in, 2)
    && $past(day_of_year_in) == $past(day_of_year_in, 2)
    |-> $stable(sunrise_time_out) && $stable(sunset_time_out)) else $error("times moved alone");
  AST_LON_RANGE: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_LONGITUDE |-> rd_data_out[23:16] <= 8'hb4
    && rd_data_out[13:8] <= 6'h3b && rd_data_out[5:0] <= 6'h3b) else $error("longitude range");
  AST_LAT_RANGE: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_LATITUDE |-> rd_data_out[23:16] <= 8'h5a
    && rd_data_out[13:8] <= 6'h3b && rd_data_out[5:0] <= 6'h3b) else $error("latitude range");
  AST_ZONE_RANGE: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_ZONE |-> $signed(rd_data_out) >= -11
    && $signed(rd_data_out) <= 12) else $error("zone range");
  AST_RISE_OFS_RANGE: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_RISE_OFS |-> $signed(rd_data_out) >= -59
    && $signed(rd_data_out) <= 59) else $error("sunrise offset range");
  AST_SET_OFS_RANGE: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_SET_OFS |-> $signed(rd_data_out) >= -59
    && $signed(rd_data_out) <= 59) else $error("sunset offset range");
  AST_TIMES_IN_DAY: assert property (
    sunrise_time_out < 11'd1440 && sunset_time_out < 11'd1440) else $error("time past midnight");
  AST_EVENTS_READ: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_EVENTS |-> rd_data_out ==
    {5'h00, $past(sunset_time_out), 5'h00, $past(sunrise_time_out)}) else $error("event word");
endmodule

bind solar_switch_block solar_switch_monitor i_solar_switch_monitor (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .current_time_of_day_in(current_time_of_day_in),
  .day_of_year_in(day_of_year_in), .rd_data_out(rd_data_out), .switch_out(switch_out),
  .sunrise_time_out(sunrise_time_out), .sunset_time_out(sunset_time_out));

// [verif/switch_consumer.sv]
`timescale 1ns/10ps

// ------------------------------------------------------------
// Downstream block that samples the switch and counts turn-ons.
// ------------------------------------------------------------
module switch_consumer (
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  input  wire logic  switch_in,
  output logic [15:0] edges_out
);
  logic        level_q;  // Last sampled switch level.
  logic        level_d;  // Next sampled level.
  logic [15:0] edges_d;  // Next count of rising switch levels.

  // A consumer sees the switch only at its own clock edges, like any control block.
  always_comb begin
    level_d = switch_in;
    edges_d = edges_out + {15'h0000, switch_in & ~level_q};
  end

  // Registers only.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      level_q   <= 1'b0;
      edges_out <= 16'h0000;
    end else begin
      level_q   <= level_d;
      edges_out <= edges_d;
    end
  end
endmodule

// [verif/solar_switch_block_bench.sv]
`timescale 1ns/10ps
`include "solar_switch_map.svh"

module solar_switch_block_bench;
  // ------------------------------------------------------------
  // Stimulus, results and counters.
  // ------------------------------------------------------------
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic [10:0] tod = 11'h000;
  logic [8:0]  doy = 9'h001;
  logic [31:0] rd_data_out;
  logic        switch_out;
  logic [10:0] sunrise_time_out;
  logic [10:0] sunset_time_out;
  logic [15:0] edges;
  logic [31:0] rd_v;
  int          fails = 0;
  int          checks_done = 0;
  int          seed = 12033;
  int          rise;
  int          set;

  solar_switch_block i_solar_switch_block (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .current_time_of_day_in(tod), .day_of_year_in(doy), .rd_data_out(rd_data_out),
    .switch_out(switch_out), .sunrise_time_out(sunrise_time_out),
    .sunset_time_out(sunset_time_out));
  switch_consumer i_switch_consumer (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .switch_in(switch_out), .edges_out(edges));

  // Free-running 8 ns clock.
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // Helpers: compare, bus cycles and the expected-value model.
  // ------------------------------------------------------------
  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 rd_v = rd_data_out;
  endtask

  function automatic int cl(int v, int lo, int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Signed arc-minutes of a position word after clamping; west and south count negative.
  function automatic int geo(logic [31:0] w, int dmax);
    return (w[24] ? -1 : 1) * (cl(int'(w[23:16]), 0, dmax) * 60 + cl(int'(w[13:8]), 0, 59));
  endfunction

  function automatic int wrapd(int v);
    return ((v % 1440) + 1440) % 1440;
  endfunction

  function automatic logic win(int r, int s, int t);
    if (r < s) return (t >= r) && (t < s);
    if (s < r) return (t >= r) || (t < s);
    return 1'b0;
  endfunction

  // Writes one configuration, then checks read-back, event times and the switch.
  task automatic run(logic [31:0] lonw, logic [31:0] latw, int z, int ro, int so,
                     logic [2:0] dst, int day);
    int noon;
    int season;
    int half;
    int tt[4];
    wr(`ADDR_LONGITUDE, lonw);
    wr(`ADDR_LATITUDE, latw);
    wr(`ADDR_ZONE, 32'(z));
    wr(`ADDR_RISE_OFS, 32'(ro));
    wr(`ADDR_SET_OFS, 32'(so));
    wr(`ADDR_SUMMERTIME, {29'h0, dst});
    doy <= 9'(day);
    repeat (3) @(posedge clk_in);
    #1;
    noon = 720 + 60 * cl(z, -11, 12) + (dst[0] ? 60 * int'(dst[2:1]) : 0) - geo(lonw, 180) / 15;
    season = 91 - ((day > 172) ? day - 172 : 172 - day);
    season = (season < -91) ? -91 : season;
    half = cl(360 + geo(latw, 90) * season / 1920, 0, 720);
    rise = wrapd(noon - half + cl(ro, -59, 59));
    set = wrapd(noon + half + cl(so, -59, 59));
    chk(32'(sunrise_time_out), 32'(rise), "sunrise");
    chk(32'(sunset_time_out), 32'(set), "sunset");
    rd(`ADDR_ZONE);
    chk(rd_v, 32'(cl(z, -11, 12)), "zone");
    rd(`ADDR_LONGITUDE);
    chk(32'(rd_v[23:16]), 32'(cl(int'(lonw[23:16]), 0, 180)), "lon deg");
    tt = '{rise, wrapd(rise - 1), set, wrapd(set - 1)};
    foreach (tt[i]) begin
      @(posedge clk_in);
      tod <= 11'(tt[i]);
      @(posedge clk_in);
      #1 chk(32'(switch_out), 32'(win(rise, set, tt[i])), "switch");
    end
    $display("config test done at %0t", $time);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence: reset, corner configurations, register checks, random ones.
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk(32'(sunrise_time_out), 32'd360, "reset sunrise");
    chk(32'(sunset_time_out), 32'd1080, "reset sunset");
    $display("reset test done");
    run(32'h01b4_3b3b, 32'h015a_3b00, 12, 59, -59, 3'h7, 172);
    run(32'h00c8_4000, 32'h005f_0000, -20, -70, 70, 3'h3, 1);
    run(32'h0000_0000, 32'h0032_0a00, -11, 0, 0, 3'h0, 366);
    run(32'h0100_0000, 32'h0100_0000, 20, 0, 0, 3'h5, 100);
    rd(`ADDR_STATUS);
    chk(32'(rd_v[1]), 32'h1, "clamp flag set");
    wr(`ADDR_STATUS, 32'h2);
    rd(`ADDR_STATUS);
    chk(32'(rd_v[1]), 32'h0, "clamp flag clear");
    wr(`ADDR_EVENTS, 32'hffff_ffff);
    rd(`ADDR_EVENTS);
    chk(rd_v, {5'h00, 11'(set), 5'h00, 11'(rise)}, "event word");
    rd(8'h20);
    chk(rd_v, 32'h0, "unmapped read");
    $display("register test done");
    repeat (20) begin
      run($random(seed) & 32'h01ff_3f3f, $random(seed) & 32'h01ff_3f3f, $random(seed) % 30,
          $random(seed) % 80, $random(seed) % 80, 3'($random(seed)),
          1 + (($random(seed) & 32'h7fff_ffff) % 366));
    end
    chk(32'(edges != 16'h0000), 32'h1, "consumer saw daylight");
    stop_test();
  end

  // A hang counts as a mismatch and ends the run through the same closing task.
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    stop_test();
  end
endmodule
